/* core/lin_uart_pkg.sv */
package lin_uart_pkg;

    // word indices; byte address is four times the index
    localparam logic [23:0] IDX_RX_BYTE_HOLDING = 24'hffe200;
    localparam logic [23:0] IDX_LINE_STATUS = 24'hffe201;
    localparam logic [23:0] IDX_CONTROL = 24'hffe20a;
    localparam logic [23:0] IDX_IRQ_STATUS = 24'hffe20b;
    localparam logic [23:0] IDX_IRQ_MASK = 24'hffe20c;

    // line status bit positions
    localparam int ST_RX_BYTE_WAITING = 7;
    localparam int ST_FAULT6 = 6;
    localparam int ST_OVERRUN = 5;
    localparam int ST_FRAMING_FAULT = 4;
    localparam int ST_BREAK_SEEN = 3;
    localparam int ST_TX_HOLDING_EMPTY = 2;
    localparam int ST_TX_IDLE = 1;
    localparam int ST_BIT0 = 0;

    // interrupt status / mask bit positions
    localparam int IRQ_RX_BYTE = 0;
    localparam int IRQ_RX_ERROR = 1;
    localparam int IRQ_BREAK = 2;
    localparam int IRQ_AUTOBAUD = 3;
    localparam int IRQ_TX_EMPTY = 4;
    localparam int IRQ_W = 5;

    // reset values
    localparam logic [4:0] CONTROL_RESET = 5'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;
    localparam logic TX_HOLDING_EMPTY_RESET = 1'b1;
    localparam logic TX_IDLE_RESET = 1'b1;

    // lin break low lengths in bit-times
    localparam logic [3:0] BRK_BITS_SLEEP = 4'h4;
    localparam logic [3:0] BRK_BITS_WAIT = 4'hb;
    localparam logic [3:0] BRK_BITS_ACTIVE = 4'ha;

    // lin protocol state reported by the lin sequencer
    localparam logic [1:0] LIN_SLEEP = 2'h0;
    localparam logic [1:0] LIN_WAIT_BREAK = 2'h1;
    localparam logic [1:0] LIN_ACTIVE = 2'h2;

    typedef struct packed {
        logic autobaud_irq_enable;
        logic clear_to_send_gating;
        logic loopback_enable;
        logic lin_slave;
        logic lin_mode;
    } ctrl_s;

    typedef struct packed {
        logic [7:0] data;
        logic parity_fault;
        logic framing_fault;
        logic all_zero;
    } rx_char_s;

endpackage

/* core/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// three-stage pin synchroniser; level moves once stages two and three agree
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_pin,
    output logic o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_r <= RESET_LEVEL;
            s2_r <= RESET_LEVEL;
            s3_r <= RESET_LEVEL;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_level <= RESET_LEVEL;
        end else if (s2_r == s3_r) begin
            o_level <= s3_r;
        end
    end
endmodule
`default_nettype wire

/* core/lin_uart_rx_status_regs.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RULE1] received byte held read-only at the transmit holding address
// [RULE2] byte waiting sets on landing, clears on holding register read
// [RULE3] uart mode parity fault set on bad parity, cleared by holding read
// [RULE4] overrun sets when a character completes with byte unread; holding read clears
// [RULE5] framing fault sets on missing stop bit, cleared by holding read
// [RULE6] uart mode break sets on all-zero character, cleared by holding read
// [RULE7] transmit holding empty sets when accepting, clears on each write
// [RULE8] transmitter idle only when shifter empty and character fully sent
// [RULE9] uart bit zero shows clear-to-send level, byte waiting in loopback
// [RULE10] clear-to-send gates transmission only while gating enable is one
// [RULE11] status layout differs between uart and lin mode, same address
// [RULE12] lin bit six flags physical mismatch; status or holding read clears
// [RULE13] lin slave baud overflow sets overrun and autobaud done
// [RULE14] lin slave autobaud done sets, may interrupt, status read clears, zero master
// [RULE15] lin break after low of 4, 11 or 10 bit-times by state
// [RULE16] overrun keeps unread byte; overrun shown after read; next read clears
// [RULE17] reset clears receive flags, sets both transmit empty flags
module lin_uart_rx_status_regs #(
    parameter int ADR_W = 26
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_rx_done,
    input wire lin_uart_pkg::rx_char_s i_rx_char,
    input wire logic i_phys_mismatch,
    input wire logic i_autobaud_char,
    input wire logic i_baud_overflow,
    input wire logic [1:0] i_lin_state,
    input wire logic i_bit_tick,
    input wire logic i_rxd,
    input wire logic i_cts_n,
    input wire logic i_tx_taken,
    input wire logic i_tx_shift_busy,
    output logic [7:0] o_tx_data,
    output logic o_tx_data_valid,
    output logic o_tx_permit,
    output logic o_irq
);
    lin_uart_pkg::ctrl_s ctrl_r;
    logic [7:0] rx_byte_holding_r;
    logic rx_byte_waiting_r;
    logic fault6_r;
    logic overrun_r;
    logic framing_fault_r;
    logic break_seen_r;
    logic autobaud_done_r;
    logic pend_ovr_r;
    logic pend_brk_r;
    logic tx_holding_empty_r;
    logic tx_idle_r;
    logic [3:0] low_bits_r;
    logic [lin_uart_pkg::IRQ_W-1:0] irq_status_r;
    logic [lin_uart_pkg::IRQ_W-1:0] irq_mask_r;
    logic cts_level;
    logic rxd_level;
    logic access;
    logic wr;
    logic rd;
    logic rx_read;
    logic status_read;
    logic rx_land;
    logic rx_overrun;
    logic lin_brk_hit;
    logic lin_slave_on;
    logic cts_seen;
    logic [3:0] brk_bits;
    logic [7:0] line_status;
    logic [lin_uart_pkg::IRQ_W-1:0] irq_events;
    logic [31:0] rd_data;

    function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [23:0] idx);
        hit = (adr[ADR_W-1:2] == idx);
    endfunction

    pin_sync #(.RESET_LEVEL(1'b1)) u_cts_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_pin(i_cts_n),
        .o_level(cts_level)
    );

    pin_sync #(.RESET_LEVEL(1'b1)) u_rxd_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_pin(i_rxd),
        .o_level(rxd_level)
    );

    // bus decode; side effects occur on the acking edge
    assign access = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wr = access && i_wb_we && i_wb_sel[0];
    assign rd = access && !i_wb_we;
    assign rx_read = rd && hit(i_wb_adr, lin_uart_pkg::IDX_RX_BYTE_HOLDING);
    assign status_read = rd && hit(i_wb_adr, lin_uart_pkg::IDX_LINE_STATUS);
    assign lin_slave_on = ctrl_r.lin_mode && ctrl_r.lin_slave;

    // [RULE16] no overwrite of an unread byte
    assign rx_land = i_rx_done && (!rx_byte_waiting_r || (rx_read && !pend_ovr_r));
    assign rx_overrun = i_rx_done && !rx_land;

    // [RULE15] break length by lin state
    always_comb begin
        unique case (i_lin_state)
            lin_uart_pkg::LIN_SLEEP: brk_bits = lin_uart_pkg::BRK_BITS_SLEEP;
            lin_uart_pkg::LIN_WAIT_BREAK: brk_bits = lin_uart_pkg::BRK_BITS_WAIT;
            lin_uart_pkg::LIN_ACTIVE: brk_bits = lin_uart_pkg::BRK_BITS_ACTIVE;
            default: brk_bits = 4'hf;
        endcase
    end

    assign lin_brk_hit = ctrl_r.lin_mode && i_bit_tick && !rxd_level && (low_bits_r + 4'h1 == brk_bits)
        && (brk_bits != 4'hf);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            low_bits_r <= 4'h0;
        end else if (rxd_level) begin
            low_bits_r <= 4'h0;
        end else if (i_bit_tick && low_bits_r != 4'hf) begin
            low_bits_r <= low_bits_r + 4'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= lin_uart_pkg::CONTROL_RESET;
        end else if (wr && hit(i_wb_adr, lin_uart_pkg::IDX_CONTROL)) begin
            ctrl_r <= i_wb_dat[4:0];
        end
    end

    // [RULE1] receive holding byte
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_byte_holding_r <= 8'h00;
        end else if (rx_land) begin
            rx_byte_holding_r <= i_rx_char.data;
        end
    end

    // [RULE2] byte waiting flag
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_byte_waiting_r <= 1'b0;
        end else if (rx_land) begin
            rx_byte_waiting_r <= 1'b1;
        end else if (rx_read) begin
            rx_byte_waiting_r <= pend_ovr_r;
        end
    end

    // [RULE16] hidden overrun until the valid byte is read
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_ovr_r <= 1'b0;
            pend_brk_r <= 1'b0;
        end else if (rx_overrun) begin
            pend_ovr_r <= 1'b1;
            pend_brk_r <= pend_brk_r || i_rx_char.all_zero;
        end else if (rx_read) begin
            pend_ovr_r <= 1'b0;
            pend_brk_r <= 1'b0;
        end
    end

    // [RULE4] overrun shows after read; [RULE13] baud overflow
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            overrun_r <= 1'b0;
        end else if (lin_slave_on && i_baud_overflow) begin
            overrun_r <= 1'b1;
        end else if (rx_read) begin
            overrun_r <= pend_ovr_r;
        end
    end

    // [RULE3] parity in uart; [RULE12] mismatch in lin
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fault6_r <= 1'b0;
        end else if (ctrl_r.lin_mode && i_phys_mismatch) begin
            fault6_r <= 1'b1;
        end else if (rx_land && !ctrl_r.lin_mode && i_rx_char.parity_fault) begin
            fault6_r <= 1'b1;
        end else if (rx_read || (ctrl_r.lin_mode && status_read)) begin
            fault6_r <= 1'b0;
        end
    end

    // [RULE5] framing fault
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            framing_fault_r <= 1'b0;
        end else if (rx_land && i_rx_char.framing_fault) begin
            framing_fault_r <= 1'b1;
        end else if (rx_read) begin
            framing_fault_r <= 1'b0;
        end
    end

    // [RULE6] uart all-zero break; [RULE15] lin break
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            break_seen_r <= 1'b0;
        end else if (lin_brk_hit || (rx_land && !ctrl_r.lin_mode && i_rx_char.all_zero)) begin
            break_seen_r <= 1'b1;
        end else if (rx_read) begin
            break_seen_r <= pend_brk_r;
        end else if (ctrl_r.lin_mode && status_read) begin
            break_seen_r <= 1'b0;
        end
    end

    // [RULE14] autobaud done, slave only
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            autobaud_done_r <= 1'b0;
        end else if (!lin_slave_on) begin
            autobaud_done_r <= 1'b0;
        end else if (i_autobaud_char || i_baud_overflow) begin
            autobaud_done_r <= 1'b1;
        end else if (status_read) begin
            autobaud_done_r <= 1'b0;
        end
    end

    // [RULE7] [RULE17] holding register, reset empty
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_holding_empty_r <= lin_uart_pkg::TX_HOLDING_EMPTY_RESET;
            o_tx_data <= 8'h00;
        end else if (wr && hit(i_wb_adr, lin_uart_pkg::IDX_RX_BYTE_HOLDING)) begin
            tx_holding_empty_r <= 1'b0;
            o_tx_data <= i_wb_dat[7:0];
        end else if (i_tx_taken) begin
            tx_holding_empty_r <= 1'b1;
        end
    end

    // [RULE8] transmitter idle
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_idle_r <= lin_uart_pkg::TX_IDLE_RESET;
        end else begin
            tx_idle_r <= tx_holding_empty_r && !i_tx_shift_busy && !i_tx_taken;
        end
    end

    // [RULE9] loopback substitutes byte waiting for the pin
    assign cts_seen = ctrl_r.loopback_enable ? rx_byte_waiting_r : cts_level;

    // [RULE10] gating of transmission
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tx_permit <= 1'b1;
            o_tx_data_valid <= 1'b0;
        end else begin
            o_tx_permit <= !ctrl_r.clear_to_send_gating || !cts_seen;
            o_tx_data_valid <= !tx_holding_empty_r;
        end
    end

    // [RULE11] mode dependent layout
    always_comb begin
        line_status = 8'h00;
        line_status[lin_uart_pkg::ST_RX_BYTE_WAITING] = rx_byte_waiting_r;
        line_status[lin_uart_pkg::ST_FAULT6] = fault6_r;
        line_status[lin_uart_pkg::ST_OVERRUN] = overrun_r;
        line_status[lin_uart_pkg::ST_FRAMING_FAULT] = framing_fault_r;
        line_status[lin_uart_pkg::ST_BREAK_SEEN] = break_seen_r;
        line_status[lin_uart_pkg::ST_TX_HOLDING_EMPTY] = tx_holding_empty_r;
        line_status[lin_uart_pkg::ST_TX_IDLE] = tx_idle_r;
        line_status[lin_uart_pkg::ST_BIT0] = ctrl_r.lin_mode ? autobaud_done_r : cts_seen;
    end

    // sticky interrupt events
    always_comb begin
        irq_events = '0;
        irq_events[lin_uart_pkg::IRQ_RX_BYTE] = rx_land;
        irq_events[lin_uart_pkg::IRQ_RX_ERROR] = rx_overrun || (lin_slave_on && i_baud_overflow)
            || (rx_land && (i_rx_char.framing_fault || (!ctrl_r.lin_mode && i_rx_char.parity_fault)))
            || (ctrl_r.lin_mode && i_phys_mismatch);
        irq_events[lin_uart_pkg::IRQ_BREAK] = lin_brk_hit || (rx_land && !ctrl_r.lin_mode && i_rx_char.all_zero);
        // [RULE14] autobaud interrupt only when enabled
        irq_events[lin_uart_pkg::IRQ_AUTOBAUD] = lin_slave_on && ctrl_r.autobaud_irq_enable && i_autobaud_char;
        irq_events[lin_uart_pkg::IRQ_TX_EMPTY] = i_tx_taken && !tx_holding_empty_r;
    end

    // write one clears; a same-cycle event wins
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_status_r <= '0;
        end else if (wr && hit(i_wb_adr, lin_uart_pkg::IDX_IRQ_STATUS)) begin
            irq_status_r <= (irq_status_r & ~i_wb_dat[lin_uart_pkg::IRQ_W-1:0]) | irq_events;
        end else begin
            irq_status_r <= irq_status_r | irq_events;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_mask_r <= lin_uart_pkg::IRQ_MASK_RESET;
        end else if (wr && hit(i_wb_adr, lin_uart_pkg::IDX_IRQ_MASK)) begin
            irq_mask_r <= i_wb_dat[lin_uart_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_status_r & irq_mask_r);
        end
    end

    // read mux; unmapped reads give zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit(i_wb_adr, lin_uart_pkg::IDX_RX_BYTE_HOLDING)) begin
            rd_data[7:0] = rx_byte_holding_r;
        end else if (hit(i_wb_adr, lin_uart_pkg::IDX_LINE_STATUS)) begin
            rd_data[7:0] = line_status;
        end else if (hit(i_wb_adr, lin_uart_pkg::IDX_CONTROL)) begin
            rd_data[4:0] = ctrl_r;
        end else if (hit(i_wb_adr, lin_uart_pkg::IDX_IRQ_STATUS)) begin
            rd_data[lin_uart_pkg::IRQ_W-1:0] = irq_status_r;
        end else if (hit(i_wb_adr, lin_uart_pkg::IDX_IRQ_MASK)) begin
            rd_data[lin_uart_pkg::IRQ_W-1:0] = irq_mask_r;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= access;
            o_wb_dat <= rd ? rd_data : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

/* dv/lin_uart_rx_status_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module lin_uart_rx_status_asserts #(
    parameter int ADR_W = 26
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic i_rx_done,
    input wire logic i_phys_mismatch,
    input wire logic i_autobaud_char,
    input wire logic i_baud_overflow,
    input wire logic i_bit_tick,
    input wire logic i_tx_taken,
    input wire logic i_tx_shift_busy,
    input wire logic [7:0] o_tx_data,
    input wire logic o_tx_data_valid,
    input wire logic o_tx_permit,
    input wire logic o_irq
);
    logic take, wr, rd_stat, wr_hold;
    lin_uart_pkg::ctrl_s ctrl_r;
    logic [4:0] mask_r;
    logic fresh_r;
    assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wr = take && i_wb_we && i_wb_sel[0];
    assign rd_stat = take && !i_wb_we && i_wb_adr[25:2] == lin_uart_pkg::IDX_LINE_STATUS;
    assign wr_hold = wr && i_wb_adr[25:2] == lin_uart_pkg::IDX_RX_BYTE_HOLDING;
    // shadow of control and mask writes
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= '0;
            mask_r <= 5'h00;
        end else if (wr && i_wb_adr[25:2] == lin_uart_pkg::IDX_CONTROL) begin
            ctrl_r <= lin_uart_pkg::ctrl_s'(i_wb_dat[4:0]);
        end else if (wr && i_wb_adr[25:2] == lin_uart_pkg::IDX_IRQ_MASK) begin
            mask_r <= i_wb_dat[4:0];
        end
    end
    // no status event seen since reset
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fresh_r <= 1'b1;
        end else if (i_rx_done | i_phys_mismatch | i_autobaud_char | i_baud_overflow | i_bit_tick | i_tx_taken
                | i_tx_shift_busy | (take && i_wb_we)) begin
            fresh_r <= 1'b0;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (take |=> o_wb_ack)
        else $error("bus request not answered next cycle");
    a_idle_dat: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data not zero outside ack");
    a_tx_hold_write: assert property (
        wr_hold ##1 !i_tx_taken |=> o_tx_data_valid && o_tx_data == $past(i_wb_dat[7:0], 2))
        else $error("transmit holding write not presented");
    a_tx_busy_view: assert property (
        rd_stat && i_tx_shift_busy && $past(i_tx_shift_busy) |=> !o_wb_dat[1])
        else $error("transmitter idle shown while shifter busy");
    a_permit_free: assert property (
        !ctrl_r.clear_to_send_gating && !$past(ctrl_r.clear_to_send_gating) |-> o_tx_permit)
        else $error("transmission blocked with gating off");
    a_loop_cts: assert property (
        rd_stat && ctrl_r.loopback_enable && !ctrl_r.lin_mode |=> o_wb_dat[0] == o_wb_dat[7])
        else $error("loopback bit zero differs from byte waiting");
    a_lin_master_ab: assert property (
        rd_stat && ctrl_r.lin_mode && !ctrl_r.lin_slave |=> !o_wb_dat[0])
        else $error("autobaud done set in lin master");
    a_reset_view: assert property (
        rd_stat && fresh_r |=> o_wb_dat[7:1] == 7'h03)
        else $error("status after reset wrong");
    a_irq_masked: assert property (mask_r == 5'h00 && $past(mask_r) == 5'h00 |-> !o_irq)
        else $error("interrupt raised with all masked");
endmodule
bind lin_uart_rx_status_regs lin_uart_rx_status_asserts #(.ADR_W(ADR_W)) i_lin_uart_rx_status_asserts (
    .i_core_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
    .i_rx_done, .i_phys_mismatch, .i_autobaud_char, .i_baud_overflow, .i_bit_tick, .i_tx_taken, .i_tx_shift_busy,
    .o_tx_data, .o_tx_data_valid, .o_tx_permit, .o_irq);
`default_nettype wire

/* dv/remote_node_model.sv */
`timescale 1ns/100ps
`default_nettype none
module remote_node_model (
    input wire logic i_core_clk,
    input wire logic i_tx_data_valid,
    output var logic o_rx_done,
    output var lin_uart_pkg::rx_char_s o_rx_char,
    output var logic o_rxd,
    output var logic o_cts_n,
    output var logic o_bit_tick,
    output var logic o_tx_taken,
    output var logic o_tx_shift_busy
);
    initial begin
        {o_rx_done, o_bit_tick, o_tx_taken, o_tx_shift_busy, o_rxd, o_cts_n} = 6'h03;
        o_rx_char = '1;
    end
    // character outside the done beat is scrambled
    task automatic send_char(input logic [7:0] d, input logic pf, input logic ff, input logic az);
        o_rx_done <= 1'b1;
        o_rx_char <= {d, pf, ff, az};
        @(posedge i_core_clk);
        o_rx_done <= 1'b0;
        o_rx_char <= ~{d, pf, ff, az};
        @(posedge i_core_clk);
    endtask
    task automatic low_bits(input int n);
        o_rxd <= 1'b0;
        repeat (5) @(posedge i_core_clk);
        repeat (n) begin
            o_bit_tick <= 1'b1;
            @(posedge i_core_clk);
            o_bit_tick <= 1'b0;
            repeat (3) @(posedge i_core_clk);
        end
    endtask
    task automatic line_idle();
        o_rxd <= 1'b1;
        repeat (5) @(posedge i_core_clk);
    endtask
    task automatic set_cts(input logic v);
        o_cts_n <= v;
    endtask
    // slow shifter: takes the byte late, then shifts for a while
    always begin
        @(posedge i_core_clk);
        if (i_tx_data_valid === 1'b1) begin
            repeat (6) @(posedge i_core_clk);
            {o_tx_taken, o_tx_shift_busy} <= 2'h3;
            @(posedge i_core_clk);
            o_tx_taken <= 1'b0;
            repeat (20) @(posedge i_core_clk);
            o_tx_shift_busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* dv/lin_uart_rx_status_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module lin_uart_rx_status_regs_bench;
    localparam logic [25:0] A_HOLD = {lin_uart_pkg::IDX_RX_BYTE_HOLDING, 2'b00};
    localparam logic [25:0] A_STAT = {lin_uart_pkg::IDX_LINE_STATUS, 2'b00};
    localparam logic [25:0] A_CTRL = {lin_uart_pkg::IDX_CONTROL, 2'b00};
    localparam logic [25:0] A_IRQ = {lin_uart_pkg::IDX_IRQ_STATUS, 2'b00};
    localparam logic [25:0] A_MASK = {lin_uart_pkg::IDX_IRQ_MASK, 2'b00};
    logic i_core_clk, i_rstn, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, i_rx_done, i_phys_mismatch;
    logic i_autobaud_char, i_baud_overflow, i_bit_tick, i_rxd, i_cts_n, i_tx_taken, i_tx_shift_busy;
    logic o_tx_data_valid, o_tx_permit, o_irq;
    logic [25:0] i_wb_adr;
    logic [3:0] i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat;
    logic [1:0] i_lin_state;
    logic [7:0] o_tx_data, q;
    lin_uart_pkg::rx_char_s i_rx_char;
    int errors, n_checks, cycles;
    lin_uart_rx_status_regs i_lin_uart_rx_status_regs (.i_core_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we,
        .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_rx_done, .i_rx_char, .i_phys_mismatch,
        .i_autobaud_char, .i_baud_overflow, .i_lin_state, .i_bit_tick, .i_rxd, .i_cts_n, .i_tx_taken,
        .i_tx_shift_busy, .o_tx_data, .o_tx_data_valid, .o_tx_permit, .o_irq);
    remote_node_model i_remote_node_model (.i_core_clk, .i_tx_data_valid(o_tx_data_valid),
        .o_rx_done(i_rx_done), .o_rx_char(i_rx_char), .o_rxd(i_rxd), .o_cts_n(i_cts_n), .o_bit_tick(i_bit_tick),
        .o_tx_taken(i_tx_taken), .o_tx_shift_busy(i_tx_shift_busy));
    always #20 i_core_clk = ~i_core_clk;
    task print_verdict();
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic wb(input logic w, input logic [25:0] a, input logic [31:0] d);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, d};
        do begin
            @(posedge i_core_clk);
        end while (o_wb_ack !== 1'b1);
        q = o_wb_dat[7:0];
        {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'h0;
        @(posedge i_core_clk);
    endtask
    task automatic st(input logic [7:0] e);
        wb(1'b0, A_STAT, 32'h0);
        `CHK("status", e, q)
    endtask
    task automatic hd(input logic [7:0] e);
        wb(1'b0, A_HOLD, 32'h0);
        `CHK("holding", e, q)
    endtask
    task automatic ev(input logic [2:0] m);
        {i_phys_mismatch, i_autobaud_char, i_baud_overflow} <= m;
        @(posedge i_core_clk);
        {i_phys_mismatch, i_autobaud_char, i_baud_overflow} <= 3'h0;
        @(posedge i_core_clk);
    endtask
    task automatic brk(input logic [1:0] s, input logic [3:0] th);
        i_lin_state <= s;
        i_remote_node_model.low_bits(int'(th) - 1);
        st(8'h06);
        i_remote_node_model.low_bits(1);
        st(8'h0e);
        i_remote_node_model.line_idle();
    endtask
    task automatic t_rx();
        i_remote_node_model.send_char(8'h5a, 1'b1, 1'b1, 1'b0);
        st(8'hd7);
        hd(8'h5a);
        st(8'h07);
        i_remote_node_model.send_char(8'h00, 1'b0, 1'b1, 1'b1);
        st(8'h9f);
        hd(8'h00);
        st(8'h07);
        i_remote_node_model.send_char(8'h11, 1'b0, 1'b0, 1'b0);
        i_remote_node_model.send_char(8'h22, 1'b0, 1'b0, 1'b0);
        st(8'h87);
        hd(8'h11);
        st(8'ha7);
        wb(1'b0, A_HOLD, 32'h0);
        st(8'h07);
    endtask
    task automatic t_tx();
        wb(1'b1, A_HOLD, 32'h0000_00a5);
        st(8'h01);
        `CHK("tx_data", 8'ha5, o_tx_data)
        while (i_tx_shift_busy !== 1'b1) @(posedge i_core_clk);
        st(8'h05);
        while (i_tx_shift_busy !== 1'b0) @(posedge i_core_clk);
        repeat (2) @(posedge i_core_clk);
        st(8'h07);
    endtask
    task automatic t_cts();
        i_remote_node_model.set_cts(1'b0);
        repeat (6) @(posedge i_core_clk);
        st(8'h06);
        wb(1'b1, A_CTRL, 32'h08);
        repeat (3) @(posedge i_core_clk);
        `CHK("permit", 1'b1, o_tx_permit)
        i_remote_node_model.set_cts(1'b1);
        repeat (6) @(posedge i_core_clk);
        `CHK("permit", 1'b0, o_tx_permit)
        wb(1'b1, A_CTRL, 32'h04);
        st(8'h06);
        i_remote_node_model.send_char(8'h33, 1'b0, 1'b0, 1'b0);
        st(8'h87);
        hd(8'h33);
    endtask
    task automatic t_lin();
        wb(1'b1, A_CTRL, 32'h13);
        st(8'h06);
        ev(3'b100);
        st(8'h46);
        st(8'h06);
        wb(1'b1, A_IRQ, 32'h1f);
        ev(3'b010);
        st(8'h07);
        st(8'h06);
        wb(1'b0, A_IRQ, 32'h0);
        `CHK("irq_status", 8'h08, q)
        ev(3'b001);
        st(8'h27);
        st(8'h26);
        wb(1'b0, A_HOLD, 32'h0);
        st(8'h06);
        brk(lin_uart_pkg::LIN_ACTIVE, lin_uart_pkg::BRK_BITS_ACTIVE);
        brk(lin_uart_pkg::LIN_SLEEP, lin_uart_pkg::BRK_BITS_SLEEP);
        brk(lin_uart_pkg::LIN_WAIT_BREAK, lin_uart_pkg::BRK_BITS_WAIT);
        i_lin_state <= 2'h3;
        wb(1'b1, A_CTRL, 32'h01);
        ev(3'b010);
        st(8'h06);
        wb(1'b1, A_CTRL, 32'h00);
    endtask
    task automatic t_irq();
        wb(1'b1, A_IRQ, 32'h1f);
        i_remote_node_model.send_char(8'h44, 1'b0, 1'b0, 1'b0);
        wb(1'b0, A_IRQ, 32'h0);
        `CHK("irq_status", 8'h01, q)
        `CHK("irq", 1'b0, o_irq)
        wb(1'b1, A_MASK, 32'h01);
        repeat (2) @(posedge i_core_clk);
        `CHK("irq", 1'b1, o_irq)
        wb(1'b1, A_IRQ, 32'h01);
        repeat (2) @(posedge i_core_clk);
        `CHK("irq", 1'b0, o_irq)
        hd(8'h44);
        wb(1'b0, 26'h3ff883c, 32'h0);
        `CHK("unmapped", 8'h00, q)
    endtask
    initial begin
        {i_core_clk, i_rstn, i_wb_cyc, i_wb_stb, i_wb_we, i_phys_mismatch, i_autobaud_char, i_baud_overflow} = 8'h00;
        {i_wb_adr, i_wb_dat, i_wb_sel, i_lin_state} = {26'h0, 32'h0, 4'h1, 2'h3};
        repeat (6) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        @(posedge i_core_clk);
        st(8'h07);
        `CHK("permit", 1'b1, o_tx_permit)
        wb(1'b0, A_MASK, 32'h0);
        `CHK("mask", 8'h00, q)
        t_rx();
        t_tx();
        t_cts();
        t_lin();
        t_irq();
        print_verdict();
    end
endmodule
`default_nettype wire
